// ===== hw/rpdwm_pkg.sv
// Package for the program ROM paging and data ROM window mapper
package rpdwm_pkg;

  // ==========================================================
  // Address space geometry
  localparam int unsigned FETCH_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned WIN_OFS_W = 6;
  localparam int unsigned VEC_COUNT = 12;

  // ==========================================================
  // Fixed address values
  localparam logic [FETCH_W-1:0] VEC_BASE = 12'hff4;
  localparam logic [1:0] WIN_TAG = 2'h1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] WIN_RST = 8'h00;

  // ==========================================================
  // Grouped carriers
  typedef struct packed {
    logic valid;
    logic [FETCH_W-1:0] addr;
  } rpdwm_fetch_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] addr;
  } rpdwm_dread_t;

  typedef struct packed {
    logic wr_bank;
    logic wr_win;
    logic [7:0] wdata;
  } rpdwm_regwr_t;

endpackage

// ===== hw/rpdwm_mapper.sv
// Program ROM paging and data ROM window address translation
`timescale 1ns/1ps

// ==========================================================
// Write-enabled holding register
// Shared by the bank select and window registers so that both clear and
// load in exactly the same way.
module rpdwm_wreg #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [W-1:0] wdata,
  // Stored value
  output logic [W-1:0] value
);

  logic [W-1:0] value_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= RST_VAL;
    end else if (wr_en) begin
      value_r <= wdata;
    end
  end

  // The new value is seen only after the write edge, so an access in the
  // same cycle as the write still uses the old page or window.
  assign value = value_r;

endmodule // rpdwm_wreg

module rpdwm_mapper #(
  parameter int unsigned ROM_AW = 13,
  parameter int unsigned BANK_W = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Core register writes
  input wire rpdwm_pkg::rpdwm_regwr_t regwr,
  // Core program fetch
  input wire rpdwm_pkg::rpdwm_fetch_t fetch,
  // Core data read
  input wire rpdwm_pkg::rpdwm_dread_t dread,
  // Shared physical ROM port, fetch has priority
  output logic rom_req,
  output logic [ROM_AW-1:0] rom_addr,
  output logic rom_is_data,
  // Pass-through data address for non-window targets
  output logic data_pass_valid,
  output logic [rpdwm_pkg::DATA_W-1:0] data_pass_addr,
  // Status
  output logic fetch_is_vector,
  output logic data_stall,
  output logic [7:0] bank_sel_q,
  output logic [7:0] win_sel_q
);

  // ==========================================================
  // Derived geometry
  // Window register bits that reach the ROM: six for 4 Kbytes, seven for 8 Kbytes.
  localparam int unsigned HI_W = ROM_AW - rpdwm_pkg::WIN_OFS_W;
  // Offset inside one 2 Kbyte program page.
  localparam int unsigned PAGE_W = rpdwm_pkg::FETCH_W - 1;
  // Data address bits above the window offset.
  localparam int unsigned TAG_W = rpdwm_pkg::DATA_W - rpdwm_pkg::WIN_OFS_W;
  // Width of the two software written registers.
  localparam int unsigned REG_W = rpdwm_pkg::DATA_W;
  // Physical page that always holds the upper visible half.
  localparam logic [BANK_W-1:0] TOP_PAGE = '1;

  // ==========================================================
  // Reset synchroniser
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_n = rst_s2_r;

  // ==========================================================
  // Bank select and window registers
  // Only the low BANK_W bits of the bank register take part in paging; the
  // upper bits are stored and read back but select nothing.
  logic [REG_W-1:0] bank_r;
  logic [REG_W-1:0] win_r;

  rpdwm_wreg #(
    .W(REG_W),
    .RST_VAL(rpdwm_pkg::BANK_RST)
  ) bank_reg (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(regwr.wr_bank),
    .wdata(regwr.wdata),
    .value(bank_r)
  );

  rpdwm_wreg #(
    .W(REG_W),
    .RST_VAL(rpdwm_pkg::WIN_RST)
  ) win_reg (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(regwr.wr_win),
    .wdata(regwr.wdata),
    .value(win_r)
  );

  assign bank_sel_q = bank_r;
  assign win_sel_q = win_r;

  // ==========================================================
  // Program fetch translation
  // Lower half: bank register forms the page bits above a 2 Kbyte offset.
  // Upper half: fixed top page TOP_PAGE (all ones), so vectors stay put.
  // A bank value equal to TOP_PAGE aliases the fixed half; software that
  // wants distinct code there must keep to the lower page numbers.
  logic fetch_lower;
  logic [PAGE_W-1:0] fetch_ofs;
  logic [BANK_W-1:0] fetch_page;
  logic [ROM_AW-1:0] fetch_phys;

  assign fetch_lower = ~fetch.addr[rpdwm_pkg::FETCH_W-1];
  assign fetch_ofs = fetch.addr[PAGE_W-1:0];

  always_comb begin
    if (fetch_lower) begin
      fetch_page = bank_r[BANK_W-1:0];
    end else begin
      fetch_page = TOP_PAGE;
    end
  end

  assign fetch_phys = ROM_AW'({fetch_page, fetch_ofs});

  // Vector area: the top VEC_COUNT bytes of the visible space.
  assign fetch_is_vector = fetch.valid && (fetch.addr >= rpdwm_pkg::VEC_BASE);

  // ==========================================================
  // Data window translation
  // 40h..7fh: the bits above the offset equal the window tag, a single 64 byte bank.
  logic in_window;
  logic win_req;
  logic [rpdwm_pkg::WIN_OFS_W-1:0] win_ofs;
  logic [HI_W-1:0] win_hi;
  logic [ROM_AW-1:0] win_phys;

  assign in_window = dread.addr[rpdwm_pkg::DATA_W-1 -: TAG_W] == rpdwm_pkg::WIN_TAG;
  assign win_req = dread.valid && in_window;
  assign win_ofs = dread.addr[rpdwm_pkg::WIN_OFS_W-1:0];
  assign win_hi = win_r[HI_W-1:0];
  assign win_phys = {win_hi, win_ofs};

  // ==========================================================
  // Shared ROM port
  // One array serves both buses; a windowed read loses to a fetch and is
  // flagged as stalled so the core can retry it. Fetch wins so that the
  // instruction flow never waits on a table read.
  typedef enum logic [1:0] {
    OWN_NONE,
    OWN_FETCH,
    OWN_DATA
  } rpdwm_owner_t;

  rpdwm_owner_t owner;

  always_comb begin
    if (fetch.valid) begin
      owner = OWN_FETCH;
    end else if (win_req) begin
      owner = OWN_DATA;
    end else begin
      owner = OWN_NONE;
    end
  end

  always_comb begin
    unique case (owner)
      OWN_FETCH: begin
        rom_addr = fetch_phys;
      end
      OWN_DATA: begin
        rom_addr = win_phys;
      end
      OWN_NONE: begin
        rom_addr = '0;
      end
      default: begin
        rom_addr = '0;
      end
    endcase
  end

  assign rom_req = owner != OWN_NONE;
  assign rom_is_data = owner == OWN_DATA;
  assign data_stall = fetch.valid && win_req;

  // ==========================================================
  // Pass-through for data addresses outside the window
  assign data_pass_valid = dread.valid && !in_window;
  assign data_pass_addr = dread.addr;

endmodule // rpdwm_mapper

// ===== bench/rpdwm_rom_model.sv
// Program ROM array model
`timescale 1ns/1ps
module rpdwm_rom_model (
  // ROM port
  input wire logic [12:0] rom_addr,
  output logic [7:0] rom_data
);
  // One array serves fetch and window reads
  assign rom_data = rom_addr[7:0] ^ {3'h0, rom_addr[12:8]};
endmodule // rpdwm_rom_model

// ===== bench/rpdwm_props.sv
// Mapper checker
`timescale 1ns/1ps
module rpdwm_props #(parameter int unsigned ROM_AW = 13, parameter int unsigned BANK_W = 2) (
  // Core side
  input wire logic mclk,
  input wire logic rstn,
  input wire rpdwm_pkg::rpdwm_regwr_t regwr,
  input wire rpdwm_pkg::rpdwm_fetch_t fetch,
  input wire rpdwm_pkg::rpdwm_dread_t dread,
  // Mapper outputs: ROM port, pass-through and status
  input wire logic [ROM_AW-1:0] rom_addr,
  input wire logic rom_is_data,
  input wire logic data_pass_valid,
  input wire logic [7:0] data_pass_addr,
  input wire logic fetch_is_vector,
  input wire logic data_stall,
  input wire logic [7:0] bank_sel_q,
  input wire logic [7:0] win_sel_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic win = dread.valid && dread.addr[7:6] == 2'h1;
  low_page_a: assert property (fetch.valid && !fetch.addr[11] |->
    rom_addr == {bank_sel_q[BANK_W-1:0], fetch.addr[10:0]}) else $error("page");
  high_fix_a: assert property (fetch.valid && fetch.addr[11] |->
    rom_addr == {{BANK_W{1'b1}}, fetch.addr[10:0]}) else $error("top");
  vec_top_a: assert property (fetch.valid |-> fetch_is_vector == (fetch.addr >= 12'hff4)) else $error("vec");
  win_addr_a: assert property (win && !fetch.valid |-> rom_is_data &&
    rom_addr == {win_sel_q[ROM_AW-7:0], dread.addr[5:0]}) else $error("win");
  win_stall_a: assert property (win && fetch.valid |-> data_stall && !rom_is_data) else $error("stall");
  pass_thru_a: assert property (dread.valid && !win |-> data_pass_addr == dread.addr) else $error("pass");
  sequence bank_load_s;
    regwr.wr_bank;
  endsequence
  sequence win_load_s;
    regwr.wr_win;
  endsequence
  bank_wr_a: assert property (bank_load_s |=> bank_sel_q == $past(regwr.wdata)) else $error("bank");
  win_wr_a: assert property (win_load_s |=> win_sel_q == $past(regwr.wdata)) else $error("wreg");
endmodule // rpdwm_props
bind rpdwm_mapper rpdwm_props #(.ROM_AW(ROM_AW), .BANK_W(BANK_W)) props (.mclk, .rstn, .regwr, .fetch, .dread,
  .rom_addr, .rom_is_data, .data_pass_valid, .data_pass_addr, .fetch_is_vector, .data_stall, .bank_sel_q, .win_sel_q);

// ===== bench/tb_rpdwm_mapper.sv
// Mapper bench
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_rpdwm_mapper;
  logic mclk = 0;
  logic rstn = 0;
  rpdwm_pkg::rpdwm_regwr_t regwr = '0;
  rpdwm_pkg::rpdwm_fetch_t fetch = '0;
  rpdwm_pkg::rpdwm_dread_t dread = '0;
  logic [12:0] rom_addr;
  logic [7:0] rom_data, data_pass_addr, bank_sel_q, win_sel_q, keep;
  logic rom_req, rom_is_data, data_pass_valid, fetch_is_vector, data_stall;
  int fails = 0;
  int cmp_count = 0;
  rpdwm_mapper #(.ROM_AW(13), .BANK_W(2)) dut (.mclk, .rstn, .regwr, .fetch, .dread, .rom_req, .rom_addr,
    .rom_is_data, .data_pass_valid, .data_pass_addr, .fetch_is_vector, .data_stall, .bank_sel_q, .win_sel_q);
  rpdwm_rom_model rom (.rom_addr, .rom_data);
  initial forever #50 mclk = ~mclk;
  task wr(input logic b, input logic [7:0] d);
    @(posedge mclk) regwr <= {b, !b, d};
    @(posedge mclk) regwr <= '0;
  endtask
  task acc(input logic [12:0] f, input logic [8:0] d);
    @(posedge mclk) fetch <= f;
    dread <= d;
    @(negedge mclk);
  endtask
  task paging;
    @(negedge mclk);
    `CHK({bank_sel_q, win_sel_q}, 16'h0)
    for (int b = 0; b < 4; b++) begin
      wr(1, 8'(b));
      acc(13'h1123, 0);
      `CHK(rom_addr, {b[1:0], 11'h123})
      acc(13'h1abc, 0);
      `CHK(rom_addr, 13'h1abc)
    end
    acc(13'h1ff4, 0);
    `CHK(fetch_is_vector, 1'b1)
    acc(13'h1ff3, 0);
    `CHK(fetch_is_vector, 1'b0)
  endtask
  task window;
    wr(0, 8'h7f);
    acc(0, 9'h17f);
    `CHK({rom_req, rom_is_data, rom_addr}, 15'h7fff)
    keep = rom_data;
    acc(13'h1fff, 0);
    `CHK(rom_data, keep)
    wr(0, 8'h00);
    acc(0, 9'h140);
    `CHK({rom_req, rom_is_data, rom_addr}, 15'h6000)
    wr(0, 8'haa);
    acc(0, 9'h155);
    `CHK(rom_addr, 13'ha95)
    acc(13'h1800, 9'h140);
    `CHK({data_stall, rom_is_data, rom_addr}, 15'h5800)
    for (int i = 0; i < 256; i += 63) begin
      acc(0, {1'b1, 8'(i)});
      `CHK({data_pass_valid, rom_req}, {i < 64 || i > 127, i inside {[64:127]}})
      `CHK(data_pass_addr, 8'(i))
    end
  endtask
  task test_done;
    $display("fails %0d of %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1;
    repeat (3) @(posedge mclk);
    paging;
    window;
    test_done;
  end
endmodule // tb_rpdwm_mapper
